// ### rtl/instr_decode_pkg.sv
// Function
// - one 14-bit word holds opcode and operands
// - sort opcodes into byte, bit, literal classes
// - ordinary instructions take one instruction cycle
// - both call forms take two cycles
// - all three return forms take two cycles
// - jumps, branches and skips take two cycles
// - indirect access to program memory adds one
// - instruction cycle is four oscillator periods
// - file operands read, modify, then store
// - file read happens even for write-only ops
// - file address operand is seven bits wide
// - bit operand selects one of eight bits
// - destination 0 accumulator, 1 file register
// - pointer operand picks pointer pair 0 or 1
// - step field picks pre/post increment/decrement
// - ignored bit positions never change behaviour
package instr_decode_pkg;
	localparam int INSTR_W = 14;
	localparam int FILE_ADDR_W = 7;
	localparam int BIT_POS_W = 3;
	localparam int LIT_W = 11;
	localparam int PHASE_W = 2;
	localparam int CYC_W = 2;
	localparam int OSC_PER_CYCLE = 4;

	// field positions inside the word
	localparam int CLASS_MSB = 13;
	localparam int CLASS_LSB = 12;
	localparam int SUBOP_MSB = 11;
	localparam int SUBOP_LSB = 8;
	localparam int BITOP_MSB = 11;
	localparam int BITOP_LSB = 10;
	localparam int DEST_BIT = 7;
	localparam int BITPOS_MSB = 9;
	localparam int BITPOS_LSB = 7;
	localparam int FADDR_MSB = 6;
	localparam int JUMP_SEL_BIT = 11;
	localparam int CTRL_SEL_MSB = 7;
	localparam int CTRL_SEL_LSB = 3;
	localparam int PTR_BIT = 2;
	localparam int STEP_MSB = 1;

	// phase and cycle values
	localparam logic [PHASE_W-1:0] PH_FETCH = 2'h0;
	localparam logic [PHASE_W-1:0] PH_READ = 2'h1;
	localparam logic [PHASE_W-1:0] PH_MODIFY = 2'h2;
	localparam logic [PHASE_W-1:0] PH_STORE = 2'h3;
	localparam logic [CYC_W-1:0] CYC_ONE = 2'h1;
	localparam logic [CYC_W-1:0] CYC_TWO = 2'h2;

	// sub-operation codes
	localparam logic [3:0] BYTE_MOVE_NOP = 4'h0;
	localparam logic [3:0] BYTE_DEC_SKIP = 4'hB;
	localparam logic [3:0] BYTE_INC_SKIP = 4'hF;
	localparam logic [1:0] BIT_CLEAR = 2'h0;
	localparam logic [1:0] BIT_SET = 2'h1;
	localparam logic [1:0] BIT_SKIP_CLEAR = 2'h2;
	localparam logic [1:0] BIT_SKIP_SET = 2'h3;
	localparam logic [3:0] LIT_CONTROL = 4'h0;
	localparam logic [3:0] LIT_RELBR_A = 4'h2;
	localparam logic [3:0] LIT_RELBR_B = 4'h3;
	localparam logic [3:0] LIT_RET_LIT = 4'h4;
	localparam logic [4:0] CTRL_RETURN = 5'h01;
	localparam logic [4:0] CTRL_RET_INT = 5'h02;
	localparam logic [4:0] CTRL_CALL_W = 5'h03;
	localparam logic [4:0] CTRL_BRANCH_W = 5'h04;
	localparam logic [4:0] CTRL_IND_LOAD = 5'h08;
	localparam logic [4:0] CTRL_IND_STORE = 5'h09;

	// file addresses that act through the pointers, and the top file address
	localparam logic [FILE_ADDR_W-1:0] IND0_ADDR = 7'h00;
	localparam logic [FILE_ADDR_W-1:0] IND1_ADDR = 7'h01;
	localparam logic [FILE_ADDR_W-1:0] FILE_ADDR_MAX = 7'h7F;

	typedef enum logic [1:0] {
		CLS_BYTE = 2'b00,
		CLS_BIT = 2'b01,
		CLS_LIT = 2'b10
	} op_class_t;

	typedef enum logic [1:0] {
		STEP_PRE_INC = 2'b00,
		STEP_PRE_DEC = 2'b01,
		STEP_POST_INC = 2'b10,
		STEP_POST_DEC = 2'b11
	} step_kind_t;

	typedef struct packed {
		op_class_t op_class;
		logic [FILE_ADDR_W-1:0] file_addr;
		logic [BIT_POS_W-1:0] bit_pos;
		logic dest_file;
		logic uses_file;
		logic stores_result;
		logic indirect;
		logic ptr_id;
		step_kind_t step_kind;
		logic [LIT_W-1:0] literal;
		logic [CYC_W-1:0] cycles;
	} decoded_t;
endpackage

// ### rtl/instruction_cycle_decode.sv
`timescale 1ns/1ns
module instruction_cycle_decode
	import instr_decode_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// instruction word from program memory
	input wire logic [INSTR_W-1:0] instr_word,
	output logic instr_take,
	// pointer state from the core, 1 = points into program memory
	input wire logic [1:0] ptr_in_prog,
	// file register data path
	input wire logic [7:0] file_rd_data,
	input wire logic [7:0] alu_result,
	output logic file_rd_stb,
	output logic file_wr_stb,
	output logic acc_wr_stb,
	output logic [7:0] operand_q,
	output logic [7:0] wr_data_q,
	// timing and decoded fields
	output logic [PHASE_W-1:0] phase_q,
	output logic instr_cycle_en,
	output logic stall,
	output decoded_t dec_q
);
	decoded_t dec_d;
	logic [CYC_W-1:0] cyc_left_q;
	logic first_q;
	logic [1:0] cls_raw;
	logic [3:0] subop;
	logic [1:0] bitop;
	logic [4:0] ctrl_sel;
	logic two_cycle;
	logic ptr_prog;

	always_comb begin
		cls_raw = instr_word[CLASS_MSB:CLASS_LSB];
		subop = instr_word[SUBOP_MSB:SUBOP_LSB];
		bitop = instr_word[BITOP_MSB:BITOP_LSB];
		ctrl_sel = instr_word[CTRL_SEL_MSB:CTRL_SEL_LSB];
	end

	always_comb begin
		dec_d = '0;
		two_cycle = 1'b0;
		dec_d.literal = instr_word[LIT_W-1:0];
		dec_d.file_addr = instr_word[FADDR_MSB:0];
		dec_d.bit_pos = instr_word[BITPOS_MSB:BITPOS_LSB];
		dec_d.ptr_id = instr_word[PTR_BIT];
		dec_d.step_kind = step_kind_t'(instr_word[STEP_MSB:0]);
		case (cls_raw)
			2'b00: begin
				dec_d.op_class = CLS_BYTE;
				dec_d.dest_file = instr_word[DEST_BIT];
				dec_d.uses_file = 1'b1;
				dec_d.stores_result = 1'b1;
				if (subop == BYTE_MOVE_NOP && !instr_word[DEST_BIT]) begin
					dec_d.uses_file = 1'b0;
					dec_d.stores_result = 1'b0;
					dec_d.file_addr = '0;
				end
				if (subop == BYTE_DEC_SKIP || subop == BYTE_INC_SKIP) begin
					two_cycle = 1'b1;
				end
			end
			2'b01: begin
				dec_d.op_class = CLS_BIT;
				dec_d.uses_file = 1'b1;
				// bit clear and set store back to the file; the skip forms store nothing
				dec_d.dest_file = 1'b1;
				dec_d.stores_result = (bitop == BIT_CLEAR) ||
					(bitop == BIT_SET);
				if (bitop == BIT_SKIP_CLEAR || bitop == BIT_SKIP_SET) begin
					two_cycle = 1'b1;
				end
			end
			2'b10: begin
				dec_d.op_class = CLS_LIT;
				two_cycle = 1'b1;
			end
			default: begin
				dec_d.op_class = CLS_LIT;
				case (subop)
					LIT_RELBR_A, LIT_RELBR_B: begin
						two_cycle = 1'b1;
					end
					LIT_RET_LIT: begin
						two_cycle = 1'b1;
					end
					LIT_CONTROL: begin
						case (ctrl_sel)
							CTRL_RETURN, CTRL_RET_INT: begin
								two_cycle = 1'b1;
							end
							CTRL_CALL_W: begin
								two_cycle = 1'b1;
							end
							CTRL_BRANCH_W: begin
								two_cycle = 1'b1;
							end
							CTRL_IND_LOAD, CTRL_IND_STORE: begin
								dec_d.indirect = 1'b1;
							end
							default: begin
								two_cycle = 1'b0;
							end
						endcase
					end
					default: begin
						two_cycle = 1'b0;
					end
				endcase
			end
		endcase
		// file operand through a pointer's window register
		if (dec_d.uses_file &&
			(dec_d.file_addr == IND0_ADDR ||
			dec_d.file_addr == IND1_ADDR)) begin
			dec_d.indirect = 1'b1;
			dec_d.ptr_id = (dec_d.file_addr == IND1_ADDR);
		end
		ptr_prog = dec_d.ptr_id ? ptr_in_prog[1] : ptr_in_prog[0];
		dec_d.cycles = two_cycle ? CYC_TWO : CYC_ONE;
		if (dec_d.indirect && ptr_prog) begin
			dec_d.cycles = dec_d.cycles + CYC_ONE;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			phase_q <= PH_FETCH;
		end else begin
			phase_q <= phase_q + 2'h1;
		end
	end

	assign instr_cycle_en = (phase_q == PH_STORE);

	// next word taken only once the current one is done
	assign instr_take = (phase_q == PH_FETCH) && (cyc_left_q == '0);
	assign stall = (cyc_left_q != '0);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cyc_left_q <= '0;
		end else if (instr_take) begin
			cyc_left_q <= dec_d.cycles - CYC_ONE;
		// count down at the start of each stalled cycle, not at the end
		// of the first one, or the next take would come a cycle early
		end else if (phase_q == PH_FETCH && cyc_left_q != '0) begin
			cyc_left_q <= cyc_left_q - CYC_ONE;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dec_q <= '0;
		end else if (instr_take) begin
			dec_q <= dec_d;
		end
	end

	// file access only in the first instruction cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			first_q <= 1'b0;
		end else if (instr_take) begin
			first_q <= 1'b1;
		end else if (instr_cycle_en) begin
			first_q <= 1'b0;
		end
	end

	assign file_rd_stb = first_q && dec_q.uses_file && (phase_q == PH_READ);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			operand_q <= 8'h00;
		end else if (file_rd_stb) begin
			operand_q <= file_rd_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wr_data_q <= 8'h00;
		end else if (first_q && dec_q.uses_file && phase_q == PH_MODIFY) begin
			wr_data_q <= alu_result;
		end
	end

	assign file_wr_stb = first_q && dec_q.uses_file &&
		dec_q.stores_result && dec_q.dest_file && (phase_q == PH_STORE);
	assign acc_wr_stb = first_q && dec_q.uses_file &&
		dec_q.stores_result && !dec_q.dest_file && (phase_q == PH_STORE);
endmodule // instruction_cycle_decode

// ### testbench/decode_checker.sv
`timescale 1ns/1ns
module decode_checker
	import instr_decode_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// fetch
	input wire logic [INSTR_W-1:0] instr_word,
	input wire logic instr_take,
	input wire logic [1:0] ptr_in_prog,
	// file data path
	input wire logic [7:0] file_rd_data,
	input wire logic [7:0] alu_result,
	input wire logic file_rd_stb,
	input wire logic file_wr_stb,
	input wire logic acc_wr_stb,
	input wire logic [7:0] operand_q,
	input wire logic [7:0] wr_data_q,
	// timing and fields
	input wire logic [PHASE_W-1:0] phase_q,
	input wire logic instr_cycle_en,
	input wire logic stall,
	input wire decoded_t dec_q
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence took(logic [1:0] n);
		instr_take ##1 dec_q.cycles == n;
	endsequence

	sequence file_op;
		instr_take ##1 dec_q.uses_file;
	endsequence

	phase_step_a: assert property (
		rst_n |=> phase_q == 2'($past(phase_q) + 2'h1))
		else $error("phase counter skipped");
	cycle_en_a: assert property (
		instr_cycle_en == (phase_q == 2'h3))
		else $error("cycle enable off phase");
	take_phase_a: assert property (
		instr_take |-> phase_q == 2'h0 && !stall)
		else $error("take outside phase zero");
	one_cycle_a: assert property (
		took(2'h1) |-> !instr_take [*3] ##1 instr_take)
		else $error("one cycle spacing wrong");
	two_cycle_a: assert property (
		took(2'h2) |-> !instr_take [*7] ##1 instr_take)
		else $error("two cycle spacing wrong");
	three_cycle_a: assert property (
		took(2'h3) |-> !instr_take [*8] ##1 !instr_take [*3] ##1 instr_take)
		else $error("three cycle spacing wrong");
	rmw_order_a: assert property (
		file_op |-> file_rd_stb ##2
		(file_wr_stb || acc_wr_stb) == dec_q.stores_result)
		else $error("read modify write order wrong");
	wr_dest_a: assert property (
		file_wr_stb || acc_wr_stb |-> phase_q == 2'h3 &&
		file_wr_stb == dec_q.dest_file && acc_wr_stb != dec_q.dest_file)
		else $error("store went to wrong place");
	operand_a: assert property (
		file_rd_stb |=> operand_q == $past(file_rd_data))
		else $error("operand not captured");
	wr_data_a: assert property (
		file_wr_stb || acc_wr_stb |-> wr_data_q == $past(alu_result))
		else $error("store data not captured");
	bit_field_a: assert property (
		instr_take && instr_word[13:12] == 2'b01 |=>
		dec_q.file_addr == $past(instr_word[6:0]) &&
		dec_q.bit_pos == $past(instr_word[9:7]))
		else $error("bit operand fields wrong");
endmodule // decode_checker

bind instruction_cycle_decode decode_checker u_decode_checker (
	.ref_clk(ref_clk), .rst_n(rst_n), .instr_word(instr_word),
	.instr_take(instr_take), .ptr_in_prog(ptr_in_prog),
	.file_rd_data(file_rd_data), .alu_result(alu_result),
	.file_rd_stb(file_rd_stb), .file_wr_stb(file_wr_stb),
	.acc_wr_stb(acc_wr_stb), .operand_q(operand_q),
	.wr_data_q(wr_data_q), .phase_q(phase_q),
	.instr_cycle_en(instr_cycle_en), .stall(stall), .dec_q(dec_q));

// ### testbench/instruction_cycle_decode_test.sv
`timescale 1ns/1ns
module instruction_cycle_decode_test
	import instr_decode_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [INSTR_W-1:0] instr_word = '0;
	logic [1:0] ptr_in_prog = '0;
	logic [7:0] file_rd_data = '0;
	logic [7:0] alu_result = '0;
	logic instr_take, file_rd_stb, file_wr_stb, acc_wr_stb;
	logic instr_cycle_en, stall;
	logic [7:0] operand_q, wr_data_q;
	logic [PHASE_W-1:0] phase_q;
	decoded_t dec_q;
	int miscompares = 0;
	int check_count = 0;
	int tk_n = 0;
	int gap = 0;
	int span = 0;
	logic [2:0] seen = '0;
	logic [2:0] snap = '0;

	instruction_cycle_decode u_instruction_cycle_decode (
		.ref_clk(ref_clk), .rst_n(rst_n), .instr_word(instr_word),
		.instr_take(instr_take), .ptr_in_prog(ptr_in_prog),
		.file_rd_data(file_rd_data), .alu_result(alu_result),
		.file_rd_stb(file_rd_stb), .file_wr_stb(file_wr_stb),
		.acc_wr_stb(acc_wr_stb), .operand_q(operand_q),
		.wr_data_q(wr_data_q), .phase_q(phase_q),
		.instr_cycle_en(instr_cycle_en), .stall(stall), .dec_q(dec_q));

	always #5 ref_clk = ~ref_clk;

	// clocks between takes and strobes seen, latched at each take
	always @(posedge ref_clk) begin
		gap <= instr_take ? 1 : gap + 1;
		if (instr_take) begin
			tk_n <= tk_n + 1;
			span <= gap;
			snap <= seen;
			seen <= '0;
		end else
			seen <= seen | {file_rd_stb, file_wr_stb, acc_wr_stb};
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// word is held until taken, since other cycles ignore it
	task automatic issue(input logic [13:0] w, input logic [1:0] p);
		int t;
		@(posedge ref_clk);
		instr_word <= w;
		ptr_in_prog <= p;
		file_rd_data <= w[7:0];
		alu_result <= ~w[7:0];
		#1 t = tk_n;
		wait (tk_n == t + 1);
		#1;
	endtask

	// strobes st = {read, file store, accumulator store}
	task automatic exec(input logic [13:0] w, input logic [1:0] p,
		input int cyc, input logic [2:0] st);
		int t;
		issue(w, p);
		t = tk_n;
		wait (tk_n == t + 1);
		#1;
		chk(8'(span), 8'(4 * cyc));
		chk({5'h0, snap}, {5'h0, st});
	endtask

	task automatic t_plain;
		exec(14'h0000, 2'h0, 1, 3'b000);
		exec(14'h00FF, 2'h0, 1, 3'b110);
		exec(14'h0B20, 2'h0, 2, 3'b101);
		exec(14'h1790, 2'h0, 1, 3'b110);
		exec(14'h007F, 2'h0, 1, 3'b000);
	endtask

	task automatic t_multi;
		exec(14'h2123, 2'h0, 2, 3'b000);
		exec(14'h3018, 2'h0, 2, 3'b000);
		exec(14'h3008, 2'h0, 2, 3'b000);
		exec(14'h3455, 2'h0, 2, 3'b000);
		exec(14'h3010, 2'h0, 2, 3'b000);
		exec(14'h2823, 2'h0, 2, 3'b000);
		exec(14'h3301, 2'h0, 2, 3'b000);
		exec(14'h3020, 2'h0, 2, 3'b000);
		exec(14'h1C05, 2'h0, 2, 3'b100);
		exec(14'h1985, 2'h0, 2, 3'b100);
		exec(14'h0FFF, 2'h0, 2, 3'b110);
		exec(14'h300F, 2'h0, 2, 3'b000);
	endtask

	task automatic t_indirect;
		exec(14'h0B80, 2'h1, 3, 3'b110);
		exec(14'h0B81, 2'h1, 2, 3'b110);
		exec(14'h0B81, 2'h2, 3, 3'b110);
	endtask

	task automatic t_fields;
		for (int i = 0; i < 8; i++) begin
			issue({6'h30, 4'h4, i[2], i[2], i[1:0]}, 2'h0);
			chk({5'h0, dec_q.ptr_id, dec_q.step_kind}, 8'(i));
		end
	endtask

	// class, literal, address and window pointer fields
	task automatic t_class;
		issue(14'h0B20, 2'h0);
		chk({6'h0, dec_q.op_class}, 8'h00);
		chk({1'b0, dec_q.file_addr}, 8'h20);
		issue(14'h1790, 2'h0);
		chk({6'h0, dec_q.op_class}, 8'h01);
		issue(14'h2FA5, 2'h0);
		chk({6'h0, dec_q.op_class}, 8'h02);
		chk(dec_q.literal[7:0], 8'hA5);
		chk({5'h0, dec_q.literal[10:8]}, 8'h07);
		issue(14'h0B81, 2'h0);
		chk({7'h0, dec_q.ptr_id}, 8'h01);
	endtask

	// reset lands in the first cycle of a three cycle instruction, one clock after its take
	task automatic t_reset;
		issue(14'h0B80, 2'h1);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		@(posedge ref_clk);
		rst_n <= 1'b1;
		#1;
		chk({5'h0, stall, phase_q}, 8'h00);
	endtask

	task automatic stop_test;
		if (miscompares == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#50000;
		miscompares++;
		stop_test();
	end

	initial begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_plain();
		t_multi();
		t_indirect();
		t_fields();
		t_class();
		t_reset();
		stop_test();
	end
endmodule // instruction_cycle_decode_test
